// *** gpcfg_pkg.sv ***
// Purpose: constants for the port e/f/g pin configuration block
// Assumes: 32-bit classic wishbone, byte addresses
// Notes:   offsets are byte addresses
package gpcfg_pkg;
    localparam logic [8:0]  OFS_E_PULL_LO  = 9'h0e4;
    localparam logic [8:0]  OFS_E_PULL_HI  = 9'h0e8;
    localparam logic [8:0]  OFS_F_FUNC     = 9'h0f0;
    localparam logic [8:0]  OFS_F_VALUE    = 9'h100;
    localparam logic [8:0]  OFS_F_DRIVE    = 9'h104;
    localparam logic [8:0]  OFS_F_PULL     = 9'h114;
    localparam logic [8:0]  OFS_G_FUNC_LO  = 9'h120;
    localparam logic [31:0] RST_PULL       = 32'h0000_0000;
    localparam logic [31:0] RST_F_FUNC     = 32'h0fff_ffff;
    localparam logic [31:0] RST_F_VALUE    = 32'h0000_0000;
    localparam logic [31:0] RST_F_DRIVE    = 32'h0111_1111;
    localparam logic [31:0] RST_G_FUNC     = 32'hffff_ffff;
    localparam logic [31:0] MSK_E_PULL_HI  = 32'h0000_000f;
    localparam logic [31:0] MSK_F_FUNC     = 32'h0fff_ffff;
    localparam logic [31:0] MSK_F_VALUE    = 32'h0000_007f;
    localparam logic [31:0] MSK_F_DRIVE    = 32'h0333_3333;
    localparam logic [31:0] MSK_F_PULL     = 32'h0000_3fff;
    localparam logic [31:0] MSK_G_FUNC     = 32'hff00_0000;
    localparam int          E_PINS         = 18;
    localparam int          F_PINS         = 7;
    localparam int          G_LO           = 6;
    localparam int          G_PINS         = 2;
    localparam logic [3:0]  FN_INPUT       = 4'h0;
    localparam logic [3:0]  FN_OUTPUT      = 4'h1;
    localparam logic [3:0]  FN_PERIPH_LO   = 4'h2;
    localparam logic [3:0]  FN_F_PERIPH_HI = 4'h6;
    localparam logic [3:0]  FN_G_PERIPH_HI = 4'h5;
    localparam logic [3:0]  FN_EINT        = 4'he;
    localparam logic [3:0]  FN_DISABLE     = 4'hf;
    localparam logic [1:0]  PULL_NONE      = 2'h0;
    localparam logic [1:0]  PULL_UP        = 2'h1;
    localparam logic [1:0]  PULL_DOWN      = 2'h2;
endpackage

// *** gpcfg_top.sv ***
// Purpose: register-controlled pin configuration for port e pulls, port f, port g pins 6..7
// Assumes: pin inputs synchronous to clk_i; single wishbone slave, ack one cycle after request
// Notes:   pad controls and peripheral selects come straight from flip-flops
// Contract
// - pull field 00 none, 01 up, 10 down, 11 selects no bias
// - port e low pull register holds pins 15..0, two bits each
// - port e high pull register holds pin 17 at 3:2, pin 16 at 1:0
// - all pull registers reset to zero
// - function 0000 input, 0001 output, 1110 interrupt, 1111 disabled
// - port f function fields pin 6..0 at 27:24..3:0, reset all disabled
// - port f codes 0010..0110 select peripheral, 0111..1001 reserved
// - input pin reads sampled level in its data bit
// - output pin drives its data register bit
// - output pin data reads back last written value
// - port f data register bits 6:0, reset zero
// - drive field selects levels 0..3, resets to level 1
// - port f drive field of pin n at bits 4n+1:4n
// - port f pull register pin 6..0 at 13:12..1:0
// - port g function pin 7 at 31:28, pin 6 at 27:24, reset disabled
// - port g codes 0010..0101 peripheral, 0110..1001 reserved, 1110 interrupt
// - port g pins 6..7 input reads level, output follows data; g_pin_o is driven at zero in every mode
//
// Implementation choice: register access over Wishbone.
module gpcfg_top (
    input  wire logic                               clk_i,
    input  wire logic                               rst_i,
    input  wire logic                               wb_cyc_i,
    input  wire logic                               wb_stb_i,
    input  wire logic                               wb_we_i,
    input  wire logic [8:0]                         wb_adr_i,
    input  wire logic [3:0]                         wb_sel_i,
    input  wire logic [31:0]                        wb_dat_i,
    output logic      [31:0]                        wb_dat_o,
    output logic                                    wb_ack_o,
    output logic                                    wb_err_o,
    input  wire logic [gpcfg_pkg::F_PINS-1:0]       f_pin_i,
    output logic      [gpcfg_pkg::F_PINS-1:0]       f_pin_o,
    output logic      [gpcfg_pkg::F_PINS-1:0]       f_pin_oe_o,
    output logic      [gpcfg_pkg::F_PINS*3-1:0]     f_periph_sel_o,
    output logic      [gpcfg_pkg::F_PINS-1:0]       f_eint_en_o,
    output logic      [gpcfg_pkg::F_PINS*2-1:0]     f_strength_o,
    output logic      [gpcfg_pkg::F_PINS-1:0]       f_pull_up_o,
    output logic      [gpcfg_pkg::F_PINS-1:0]       f_pull_down_o,
    output logic      [gpcfg_pkg::E_PINS-1:0]       e_pull_up_o,
    output logic      [gpcfg_pkg::E_PINS-1:0]       e_pull_down_o,
    input  wire logic [gpcfg_pkg::G_PINS-1:0]       g_pin_i,
    output logic      [gpcfg_pkg::G_PINS-1:0]       g_pin_o,
    output logic      [gpcfg_pkg::G_PINS-1:0]       g_pin_oe_o,
    output logic      [gpcfg_pkg::G_PINS*3-1:0]     g_periph_sel_o,
    output logic      [gpcfg_pkg::G_PINS-1:0]       g_eint_en_o,
    output logic      [gpcfg_pkg::G_PINS-1:0]       g_pin_value_o
);

    localparam int FP = gpcfg_pkg::F_PINS;
    localparam int GP = gpcfg_pkg::G_PINS;
    localparam int EP = gpcfg_pkg::E_PINS;

    logic [31:0]   port_e_pull_low_r;
    logic [31:0]   port_e_pull_high_r;
    logic [31:0]   port_f_function_select_r;
    logic [31:0]   port_f_pin_value_r;
    logic [31:0]   port_f_drive_strength_r;
    logic [31:0]   port_f_pull_select_r;
    logic [31:0]   port_g_function_select_low_r;
    logic [GP-1:0] port_g_pin_value_r;
    logic [31:0]   rd_nxt;
    logic          hit;
    logic          req;
    logic [35:0]   e_pull_all;

    // merge write data under byte enables and the writable mask
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] sel, input logic [31:0] msk);
        logic [31:0] be;
        be = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
        return ((old & ~(be & msk)) | (wd & be & msk));
    endfunction

    // peripheral index 1..n for codes lo..hi, zero otherwise
    function automatic logic [2:0] periph(input logic [3:0] code, input logic [3:0] hi);
        logic [3:0] d;
        d = code - gpcfg_pkg::FN_PERIPH_LO + 4'h1;
        if (code >= gpcfg_pkg::FN_PERIPH_LO && code <= hi)
            return d[2:0];
        return 3'h0;
    endfunction

    function automatic logic pull_up(input logic [1:0] f);
        return f == gpcfg_pkg::PULL_UP;
    endfunction

    function automatic logic pull_dn(input logic [1:0] f);
        return f == gpcfg_pkg::PULL_DOWN;
    endfunction

    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;

    always_comb begin
        hit = 1'b1;
        rd_nxt = 32'h0;
        case (wb_adr_i)
            gpcfg_pkg::OFS_E_PULL_LO: rd_nxt = port_e_pull_low_r;
            gpcfg_pkg::OFS_E_PULL_HI: rd_nxt = port_e_pull_high_r;
            gpcfg_pkg::OFS_F_FUNC:    rd_nxt = port_f_function_select_r;
            gpcfg_pkg::OFS_F_VALUE: begin
                for (int i = 0; i < FP; i++) begin
                    // input pins show the pad, others the stored bit
                    if (port_f_function_select_r[4*i +: 4] == gpcfg_pkg::FN_INPUT)
                        rd_nxt[i] = f_pin_i[i];
                    else
                        rd_nxt[i] = port_f_pin_value_r[i];
                end
            end
            gpcfg_pkg::OFS_F_DRIVE:   rd_nxt = port_f_drive_strength_r;
            gpcfg_pkg::OFS_F_PULL:    rd_nxt = port_f_pull_select_r;
            gpcfg_pkg::OFS_G_FUNC_LO: rd_nxt = port_g_function_select_low_r;
            default:                  hit = 1'b0;
        endcase
    end

    // bus answer: ack or err one cycle after request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= req && hit;
            wb_err_o <= req && !hit;
            wb_dat_o <= (req && hit && !wb_we_i) ? rd_nxt : 32'h0;
        end
    end

    // register writes; masks keep unused bits at zero, except port g function bits 23:0, which are writable and reset to ones
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port_e_pull_low_r            <= gpcfg_pkg::RST_PULL;
            port_e_pull_high_r           <= gpcfg_pkg::RST_PULL;
            port_f_function_select_r     <= gpcfg_pkg::RST_F_FUNC;
            port_f_pin_value_r           <= gpcfg_pkg::RST_F_VALUE;
            port_f_drive_strength_r      <= gpcfg_pkg::RST_F_DRIVE;
            port_f_pull_select_r         <= gpcfg_pkg::RST_PULL;
            port_g_function_select_low_r <= gpcfg_pkg::RST_G_FUNC;
        end else if (req && hit && wb_we_i) begin
            case (wb_adr_i)
                gpcfg_pkg::OFS_E_PULL_LO:
                    port_e_pull_low_r <= merge(port_e_pull_low_r, wb_dat_i, wb_sel_i, 32'hffff_ffff);
                gpcfg_pkg::OFS_E_PULL_HI:
                    port_e_pull_high_r <= merge(port_e_pull_high_r, wb_dat_i, wb_sel_i,
                                                gpcfg_pkg::MSK_E_PULL_HI);
                gpcfg_pkg::OFS_F_FUNC:
                    port_f_function_select_r <= merge(port_f_function_select_r, wb_dat_i, wb_sel_i,
                                                      gpcfg_pkg::MSK_F_FUNC);
                gpcfg_pkg::OFS_F_VALUE:
                    port_f_pin_value_r <= merge(port_f_pin_value_r, wb_dat_i, wb_sel_i,
                                                gpcfg_pkg::MSK_F_VALUE);
                gpcfg_pkg::OFS_F_DRIVE:
                    port_f_drive_strength_r <= merge(port_f_drive_strength_r, wb_dat_i, wb_sel_i,
                                                     gpcfg_pkg::MSK_F_DRIVE);
                gpcfg_pkg::OFS_F_PULL:
                    port_f_pull_select_r <= merge(port_f_pull_select_r, wb_dat_i, wb_sel_i,
                                                  gpcfg_pkg::MSK_F_PULL);
                gpcfg_pkg::OFS_G_FUNC_LO:
                    port_g_function_select_low_r <= merge(port_g_function_select_low_r, wb_dat_i,
                                                          wb_sel_i, 32'hffff_ffff);
                default: ;
            endcase
        end
    end

    // port g data bits live outside this block; pins 6..7 input levels are sampled here each cycle
    always_ff @(posedge clk_i) begin
        if (rst_i)
            port_g_pin_value_r <= '0;
        else
            port_g_pin_value_r <= g_pin_i;
    end

    assign e_pull_all = {port_e_pull_high_r[3:0], port_e_pull_low_r};

    // port e pull pad controls
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            e_pull_up_o   <= '0;
            e_pull_down_o <= '0;
        end else begin
            for (int i = 0; i < EP; i++) begin
                e_pull_up_o[i]   <= pull_up(e_pull_all[2*i +: 2]);
                e_pull_down_o[i] <= pull_dn(e_pull_all[2*i +: 2]);
            end
        end
    end

    // port f pad controls
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            f_pin_o        <= '0;
            f_pin_oe_o     <= '0;
            f_periph_sel_o <= '0;
            f_eint_en_o    <= '0;
            f_strength_o   <= '0;
            f_pull_up_o    <= '0;
            f_pull_down_o  <= '0;
        end else begin
            for (int i = 0; i < FP; i++) begin
                f_pin_o[i]            <= port_f_pin_value_r[i];
                f_pin_oe_o[i]         <= port_f_function_select_r[4*i +: 4] == gpcfg_pkg::FN_OUTPUT;
                f_periph_sel_o[3*i +: 3] <= periph(port_f_function_select_r[4*i +: 4],
                                                   gpcfg_pkg::FN_F_PERIPH_HI);
                f_eint_en_o[i]        <= port_f_function_select_r[4*i +: 4] == gpcfg_pkg::FN_EINT;
                f_strength_o[2*i +: 2] <= port_f_drive_strength_r[4*i +: 2];
                f_pull_up_o[i]        <= pull_up(port_f_pull_select_r[2*i +: 2]);
                f_pull_down_o[i]      <= pull_dn(port_f_pull_select_r[2*i +: 2]);
            end
        end
    end

    // port g pins 6..7 pad controls; codes 1010..1101 fall through to nothing
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            g_pin_o        <= '0;
            g_pin_oe_o     <= '0;
            g_periph_sel_o <= '0;
            g_eint_en_o    <= '0;
            g_pin_value_o  <= '0;
        end else begin
            for (int i = 0; i < GP; i++) begin
                g_pin_oe_o[i] <= port_g_function_select_low_r[4*(i+gpcfg_pkg::G_LO) +: 4]
                                 == gpcfg_pkg::FN_OUTPUT;
                g_periph_sel_o[3*i +: 3] <= periph(port_g_function_select_low_r[4*(i+gpcfg_pkg::G_LO) +: 4],
                                                   gpcfg_pkg::FN_G_PERIPH_HI);
                g_eint_en_o[i] <= port_g_function_select_low_r[4*(i+gpcfg_pkg::G_LO) +: 4]
                                  == gpcfg_pkg::FN_EINT;
            end
            g_pin_o       <= '0;
            g_pin_value_o <= port_g_pin_value_r;
        end
    end

    AST_ACK_ONE: assert property (
        @(posedge clk_i) disable iff (rst_i)
        req && hit |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not one cycle");

    AST_UNMAPPED: assert property (
        @(posedge clk_i) disable iff (rst_i)
        req && !hit |=> wb_err_o && !wb_ack_o)
        else $error("unmapped not refused");

    AST_HI_UNUSED: assert property (
        @(posedge clk_i) disable iff (rst_i)
        port_e_pull_high_r[31:4] == 28'h0)
        else $error("e high unused bits set");

    AST_F_UNUSED: assert property (
        @(posedge clk_i) disable iff (rst_i)
        port_f_pin_value_r[31:7] == 25'h0 && port_f_function_select_r[31:28] == 4'h0)
        else $error("f unused set");

    AST_DRV_UNUSED: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (port_f_drive_strength_r & ~gpcfg_pkg::MSK_F_DRIVE) == 32'h0)
        else $error("drive unused set");

    AST_PULL_EXCL: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (f_pull_up_o & f_pull_down_o) == '0 && (e_pull_up_o & e_pull_down_o) == '0)
        else $error("both pulls");

    AST_OUT_FOLLOW: assert property (
        @(posedge clk_i) disable iff (rst_i)
        1'b1 |=> f_pin_o == $past(port_f_pin_value_r[FP-1:0]))
        else $error("f pin not following data");

    AST_OE_CODE: assert property (
        @(posedge clk_i) disable iff (rst_i)
        port_f_function_select_r[3:0] == gpcfg_pkg::FN_DISABLE |=> !f_pin_oe_o[0] && f_periph_sel_o[2:0] == 3'h0)
        else $error("disabled pin active");

    AST_RESET_DEF: assert property (
        @(posedge clk_i)
        rst_i |=> port_f_drive_strength_r == gpcfg_pkg::RST_F_DRIVE
        && port_g_function_select_low_r == gpcfg_pkg::RST_G_FUNC)
        else $error("reset default wrong");

    AST_F_PULL_RSV: assert property (
        @(posedge clk_i) disable iff (rst_i)
        &port_f_pull_select_r[7:6] |=> !f_pull_up_o[3] && !f_pull_down_o[3])
        else $error("reserved pull biased");

    AST_E_LO_MAP: assert property (
        @(posedge clk_i) disable iff (rst_i)
        port_e_pull_low_r[29:28] == gpcfg_pkg::PULL_DOWN |=> e_pull_down_o[14])
        else $error("e pin 14 pull wrong");

    AST_E_HI_MAP: assert property (
        @(posedge clk_i) disable iff (rst_i)
        port_e_pull_high_r[3:2] == gpcfg_pkg::PULL_UP |=> e_pull_up_o[17])
        else $error("e pin 17 pull wrong");

    AST_PULL_RESET: assert property (
        @(posedge clk_i)
        rst_i |=> port_e_pull_low_r == gpcfg_pkg::RST_PULL && port_e_pull_high_r == gpcfg_pkg::RST_PULL
        && port_f_pull_select_r == gpcfg_pkg::RST_PULL)
        else $error("pull reset wrong");

    AST_EINT_CODE: assert property (
        @(posedge clk_i) disable iff (rst_i)
        port_f_function_select_r[27:24] == gpcfg_pkg::FN_EINT |=> f_eint_en_o[6] && !f_pin_oe_o[6])
        else $error("f interrupt select wrong");

    AST_F_FUNC_RESET: assert property (
        @(posedge clk_i)
        rst_i |=> port_f_function_select_r == gpcfg_pkg::RST_F_FUNC)
        else $error("f function reset wrong");

    AST_F_RESERVED: assert property (
        @(posedge clk_i) disable iff (rst_i)
        port_f_function_select_r[7:4] inside {4'h7, 4'h8, 4'h9} |=> f_periph_sel_o[5:3] == 3'h0)
        else $error("f reserved code routed");

    AST_F_PERIPH: assert property (
        @(posedge clk_i) disable iff (rst_i)
        port_f_function_select_r[3:0] == gpcfg_pkg::FN_F_PERIPH_HI |=> f_periph_sel_o[2:0] == 3'h5)
        else $error("f top peripheral wrong");

    AST_READ_INPUT: assert property (
        @(posedge clk_i) disable iff (rst_i)
        req && !wb_we_i && wb_adr_i == gpcfg_pkg::OFS_F_VALUE
        && port_f_function_select_r[3:0] == gpcfg_pkg::FN_INPUT |=> wb_dat_o[0] == $past(f_pin_i[0]))
        else $error("input level not read");

    AST_READ_OUTPUT: assert property (
        @(posedge clk_i) disable iff (rst_i)
        req && !wb_we_i && wb_adr_i == gpcfg_pkg::OFS_F_VALUE
        && port_f_function_select_r[3:0] == gpcfg_pkg::FN_OUTPUT |=> wb_dat_o[0] == $past(port_f_pin_value_r[0]))
        else $error("output data not read back");

    AST_F_VALUE_RESET: assert property (
        @(posedge clk_i)
        rst_i |=> port_f_pin_value_r == gpcfg_pkg::RST_F_VALUE)
        else $error("f data reset wrong");

    AST_STRENGTH: assert property (
        @(posedge clk_i) disable iff (rst_i)
        1'b1 |=> f_strength_o[13:12] == $past(port_f_drive_strength_r[25:24]))
        else $error("pin 6 strength wrong");

    AST_F_PULL_UNUSED: assert property (
        @(posedge clk_i) disable iff (rst_i)
        port_f_pull_select_r[31:14] == 18'h0)
        else $error("f pull unused set");

    AST_G_EINT: assert property (
        @(posedge clk_i) disable iff (rst_i)
        port_g_function_select_low_r[31:28] == gpcfg_pkg::FN_EINT |=> g_eint_en_o[1] && g_periph_sel_o[5:3] == 3'h0)
        else $error("g interrupt select wrong");

    AST_G_RESERVED: assert property (
        @(posedge clk_i) disable iff (rst_i)
        port_g_function_select_low_r[27:24] == 4'h6 |=> g_periph_sel_o[2:0] == 3'h0)
        else $error("g reserved code routed");

    AST_G_LEVEL: assert property (
        @(posedge clk_i) disable iff (rst_i)
        1'b1 |=> g_pin_value_o == $past(port_g_pin_value_r))
        else $error("g level not shown");

    AST_RSV_HIGH: assert property (
        @(posedge clk_i) disable iff (rst_i)
        port_f_function_select_r[11:8] inside {[4'ha:4'hd]} |=> f_periph_sel_o[8:6] == 3'h0 && !f_pin_oe_o[2])
        else $error("high reserved code active");

    AST_ERR_NO_DATA: assert property (
        @(posedge clk_i) disable iff (rst_i)
        req && !hit |=> wb_dat_o == 32'h0)
        else $error("data on refused access");

    AST_ACK_ERR_EXCL: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !(wb_ack_o && wb_err_o))
        else $error("ack and err together");

    COV_WRITE: cover property (@(posedge clk_i) disable iff (rst_i) req && hit && wb_we_i ##1 wb_ack_o);
    COV_READ: cover property (@(posedge clk_i) disable iff (rst_i) req && hit && !wb_we_i ##1 wb_ack_o);
    COV_ERR: cover property (@(posedge clk_i) disable iff (rst_i) wb_err_o);
    COV_OUT: cover property (@(posedge clk_i) disable iff (rst_i) |f_pin_oe_o);
    COV_EINT: cover property (@(posedge clk_i) disable iff (rst_i) |f_eint_en_o);

endmodule

// *** gpcfg_pad_model.sv ***
// Purpose: pads and external sources on the far side of port f and port g pins
// Assumes: pad outputs combinational from design controls and bench levels
// Notes:   an undriven, unbiased pad takes the external level from the bench
module gpcfg_pad_model (
    input  wire logic [6:0] f_out_i,
    input  wire logic [6:0] f_oe_i,
    input  wire logic [6:0] f_up_i,
    input  wire logic [6:0] f_dn_i,
    input  wire logic [6:0] f_ext_i,
    output logic      [6:0] f_pad_o,
    input  wire logic [1:0] g_out_i,
    input  wire logic [1:0] g_oe_i,
    input  wire logic [1:0] g_ext_i,
    output logic      [1:0] g_pad_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // driven pad follows its output, else bias, else external source
    assign f_pad_o = (f_oe_i & f_out_i) | (~f_oe_i & f_up_i) | (~f_oe_i & ~f_up_i & ~f_dn_i & f_ext_i);
    assign g_pad_o = (g_oe_i & g_out_i) | (~g_oe_i & g_ext_i);
endmodule

// *** gpcfg_top_tb_top.sv ***
// Purpose: self-checking bench for the pin configuration block
// Assumes: classic wishbone, ack or err one cycle after request
// Notes:   data bits of peripheral pins are never compared
module gpcfg_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o, er;
    logic [8:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic [6:0]  f_pin_i, f_pin_o, f_pin_oe_o, f_eint_en_o, f_pull_up_o, f_pull_down_o, f_ext;
    logic [20:0] f_periph_sel_o;
    logic [13:0] f_strength_o;
    logic [17:0] e_pull_up_o, e_pull_down_o;
    logic [1:0]  g_pin_i, g_pin_o, g_pin_oe_o, g_eint_en_o, g_pin_value_o, g_ext;
    logic [5:0]  g_periph_sel_o;
    int          num_errors, check_count;
    gpcfg_top u_gpcfg_top (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
        .wb_dat_o, .wb_ack_o, .wb_err_o, .f_pin_i, .f_pin_o, .f_pin_oe_o, .f_periph_sel_o, .f_eint_en_o,
        .f_strength_o, .f_pull_up_o, .f_pull_down_o, .e_pull_up_o, .e_pull_down_o, .g_pin_i, .g_pin_o,
        .g_pin_oe_o, .g_periph_sel_o, .g_eint_en_o, .g_pin_value_o);
    gpcfg_pad_model u_gpcfg_pad_model (.f_out_i(f_pin_o), .f_oe_i(f_pin_oe_o), .f_up_i(f_pull_up_o),
        .f_dn_i(f_pull_down_o), .f_ext_i(f_ext), .f_pad_o(f_pin_i), .g_out_i(g_pin_o), .g_oe_i(g_pin_oe_o),
        .g_ext_i(g_ext), .g_pad_o(g_pin_i));
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic xfer(input logic w, input logic [8:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_we_i <= w; wb_adr_i <= a; wb_dat_i <= d; wb_sel_i <= 4'hf;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20);
        if (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1) begin
            num_errors++;
            $display("Error at %0t: bus answer missing", $time);
            stop_test();
        end
        rd = wb_dat_o;
        er = wb_err_o;
        wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0; wb_we_i <= 1'b0;
    endtask
    task automatic rdchk(input logic [8:0] a, input logic [31:0] e, input string m);
        xfer(1'b0, a, 32'h0);
        check(rd, e, m);
    endtask
    task automatic settle;
        repeat (3) @(posedge clk_i);
    endtask
    task automatic t_reset;
        rdchk(gpcfg_pkg::OFS_E_PULL_LO, gpcfg_pkg::RST_PULL, "e pull lo rst");
        rdchk(gpcfg_pkg::OFS_E_PULL_HI, gpcfg_pkg::RST_PULL, "e pull hi rst");
        rdchk(gpcfg_pkg::OFS_F_FUNC, gpcfg_pkg::RST_F_FUNC, "f func rst");
        rdchk(gpcfg_pkg::OFS_F_VALUE, gpcfg_pkg::RST_F_VALUE, "f data rst");
        rdchk(gpcfg_pkg::OFS_F_DRIVE, gpcfg_pkg::RST_F_DRIVE, "f drive rst");
        rdchk(gpcfg_pkg::OFS_F_PULL, gpcfg_pkg::RST_PULL, "f pull rst");
        rdchk(gpcfg_pkg::OFS_G_FUNC_LO, gpcfg_pkg::RST_G_FUNC, "g func rst");
        check(f_strength_o, 14'h1555, "strength rst");
        $display("test reset done");
    endtask
    task automatic t_pull;
        xfer(1'b1, gpcfg_pkg::OFS_E_PULL_LO, 32'he4e4_e4e4);
        xfer(1'b1, gpcfg_pkg::OFS_E_PULL_HI, 32'hffff_ffe6);
        xfer(1'b1, gpcfg_pkg::OFS_F_PULL, 32'hffff_e4e4);
        settle();
        check(e_pull_up_o, 18'h22222, "e up");
        check(e_pull_down_o, 18'h14444, "e down");
        check(f_pull_up_o, 7'h22, "f up");
        check(f_pull_down_o, 7'h44, "f down");
        rdchk(gpcfg_pkg::OFS_E_PULL_HI, 32'h6, "e pull hi");
        rdchk(gpcfg_pkg::OFS_F_PULL, 32'h24e4, "f pull");
        $display("test pull done");
    endtask
    task automatic t_drive;
        xfer(1'b1, gpcfg_pkg::OFS_F_DRIVE, 32'hffff_ffff);
        rdchk(gpcfg_pkg::OFS_F_DRIVE, 32'h0333_3333, "drive rb");
        xfer(1'b1, gpcfg_pkg::OFS_F_DRIVE, 32'h0000_3210);
        settle();
        check(f_strength_o, 14'h00e4, "strength");
        $display("test drive done");
    endtask
    task automatic t_func;
        logic [3:0] c;
        logic [2:0] fs, gs;
        for (int i = 0; i < 16; i++) begin
            c = i[3:0];
            fs = (c >= 4'h2 && c <= 4'h6) ? 3'(c - 4'h1) : 3'h0;
            gs = (c >= 4'h2 && c <= 4'h5) ? 3'(c - 4'h1) : 3'h0;
            xfer(1'b1, gpcfg_pkg::OFS_F_FUNC, {8{c}});
            xfer(1'b1, gpcfg_pkg::OFS_G_FUNC_LO, {8{c}});
            settle();
            check(f_pin_oe_o, (c == 4'h1) ? 7'h7f : 7'h0, "f oe");
            check(f_eint_en_o, (c == 4'he) ? 7'h7f : 7'h0, "f eint");
            check(f_periph_sel_o, {7{fs}}, "f periph");
            check({g_pin_oe_o, g_eint_en_o}, {{2{c == 4'h1}}, {2{c == 4'he}}}, "g oe eint");
            check(g_periph_sel_o, {2{gs}}, "g periph");
            rdchk(gpcfg_pkg::OFS_G_FUNC_LO, {8{c}}, "g func rb");
        end
        xfer(1'b1, gpcfg_pkg::OFS_F_FUNC, 32'hf654_3210);
        xfer(1'b1, gpcfg_pkg::OFS_G_FUNC_LO, 32'he100_0000);
        settle();
        check(f_periph_sel_o, {3'd5, 3'd4, 3'd3, 3'd2, 3'd1, 6'd0}, "f layout");
        check({g_pin_oe_o, g_eint_en_o}, 4'b0110, "g layout");
        rdchk(gpcfg_pkg::OFS_F_FUNC, 32'h0654_3210, "f func rb");
        $display("test function done");
    endtask
    task automatic t_data;
        xfer(1'b1, gpcfg_pkg::OFS_F_FUNC, 32'h0111_1111);
        xfer(1'b1, gpcfg_pkg::OFS_F_VALUE, 32'hffff_ff55);
        settle();
        check(f_pin_o, 7'h55, "f out");
        rdchk(gpcfg_pkg::OFS_F_VALUE, 32'h55, "f data out rb");
        xfer(1'b1, gpcfg_pkg::OFS_F_FUNC, 32'h0);
        xfer(1'b1, gpcfg_pkg::OFS_F_PULL, 32'h0);
        xfer(1'b1, gpcfg_pkg::OFS_G_FUNC_LO, 32'h0);
        f_ext <= 7'h2a;
        g_ext <= 2'b10;
        settle();
        rdchk(gpcfg_pkg::OFS_F_VALUE, 32'h2a, "f data in");
        check(g_pin_value_o, 2'b10, "g level");
        check(g_pin_o, 2'b00, "g out");
        $display("test data done");
    endtask
    task automatic t_unmapped;
        xfer(1'b1, 9'h0ec, 32'h1);
        check(er, 1'b1, "err write");
        xfer(1'b0, 9'h0ec, 32'h0);
        check(er, 1'b1, "err read");
        rdchk(gpcfg_pkg::OFS_E_PULL_LO, 32'he4e4_e4e4, "kept");
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rdchk(gpcfg_pkg::OFS_E_PULL_LO, gpcfg_pkg::RST_PULL, "re-reset pull");
        rdchk(gpcfg_pkg::OFS_F_FUNC, gpcfg_pkg::RST_F_FUNC, "re-reset func");
        $display("test unmapped and reset done");
    endtask
    initial begin
        rst_i = 1'b1; wb_cyc_i = 1'b0; wb_stb_i = 1'b0; wb_we_i = 1'b0;
        wb_adr_i = 9'h0; wb_sel_i = 4'h0; wb_dat_i = 32'h0;
        f_ext = 7'h0; g_ext = 2'h0; num_errors = 0; check_count = 0;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_pull();
        t_drive();
        t_func();
        t_data();
        t_unmapped();
        stop_test();
    end
endmodule
